// ===== ledcp_top.sv
// Command port of an eight-channel LED driver: bus target, staged and active settings.
// Assumes SCL and SDA are open-drain lines resolved outside and sampled on MCLK.
//
// What this block does
// - Acts only as bus target; never drives the clock or starts transfers.
// - Answers only the fixed seven-bit address 0011011; others are ignored.
// - Direction bit after the address: one means read, zero means write.
// - Command byte: upper three bits command code, lower five bits register index.
// - In a write the address, command and data bytes are each acknowledged.
// - Read phase: acknowledge, send one byte, release data; controller ends it.
// - Code 000 switches all channels from output control; index and data ignored.
// - Code 001 stores data as staged value; outputs change only on 000 or 010.
// - Code 010 writes the indexed register, then switches all channels.
// - Switched channels take current and duty from their own registers.
// - Code 011 loads all eight current levels; index ignored; stays staged.
// - Code 100 loads all eight duty registers; index ignored; stays staged.
// - Eighteen registers: eight levels, eight duties, output control, status.
// - Output control holds one on or off bit per channel.
// - Status reports normal or over-temperature condition; low power ends at the start of a read, so it never reads back.
// - Level, duty and output control registers read back the bits last written; status reads the live condition.
// - Current level is a five-bit code of 32 levels.
// - Duty is a six-bit code of 64 settings.
// - Low power after about 5 ms with outputs off and bus quiet.
`timescale 1ns/1ps
module ledcp_top #(
   parameter int LP_CYCLES = ledcp_pkg::LP_CYCLES
) (
   input logic MCLK,
   input logic RST,
   input logic SCL,
   input logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE,
   input logic OVER_TEMP,
   output logic [ledcp_pkg::NCH-1:0] CH_ON,
   output ledcp_pkg::ledcp_chan_t [ledcp_pkg::NCH-1:0] CH_SET,
   output logic LOW_POWER
);
   import ledcp_pkg::*;

   // ******************************************************************
   // Pin sampling and bus conditions
   // ******************************************************************
   ledcp_pins_t pins_raw;
   ledcp_pins_t pins_s;
   logic scl_prev_q;
   logic sda_prev_q;
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;

   assign pins_raw = '{scl: SCL, sda: SDA_IN, over_temp: OVER_TEMP};

   // Bus lines reset to their idle high level, so no false edge follows reset.
   ledcp_sync #(
      .W($bits(ledcp_pins_t)),
      .RST_VAL(ledcp_pins_t'{scl: 1'b1, sda: 1'b1, over_temp: 1'b0})
   ) u_sync (
      .clk(MCLK),
      .rst(RST),
      .d(pins_raw),
      .q(pins_s)
   );

   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
      begin
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end
      else
      begin
         scl_prev_q <= pins_s.scl;
         sda_prev_q <= pins_s.sda;
      end
   end

   // The clock is only ever watched, never driven.
   assign scl_rise = pins_s.scl & ~scl_prev_q;
   assign scl_fall = ~pins_s.scl & scl_prev_q;
   assign bus_start = scl_prev_q & pins_s.scl & sda_prev_q & ~pins_s.sda;
   assign bus_stop = scl_prev_q & pins_s.scl & ~sda_prev_q & pins_s.sda;

   // ******************************************************************
   // Byte shifter and protocol sequencer
   // ******************************************************************
   ledcp_state_t state_q;
   logic [3:0] bit_cnt_q;
   logic [7:0] shift_q;
   logic [7:0] tx_q;
   logic [7:0] rd_byte;
   logic byte_done;
   logic addr_hit;
   logic in_byte;

   assign byte_done = scl_fall && (bit_cnt_q == BYTE_BITS);
   assign addr_hit = (shift_q[7:1] == DEV_ADDR);
   assign in_byte = (state_q == ST_ADDR) || (state_q == ST_CMD) ||
                    (state_q == ST_DATA) || (state_q == ST_RDAT);

   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
      begin
         bit_cnt_q <= 4'h0;
         shift_q <= 8'h00;
      end
      else if (bus_start)
      begin
         bit_cnt_q <= 4'h0;
      end
      else if (scl_rise && in_byte)
      begin
         bit_cnt_q <= bit_cnt_q + 4'h1;
         shift_q <= {shift_q[6:0], pins_s.sda};
      end
      else if (scl_fall && (byte_done || !in_byte))
      begin
         bit_cnt_q <= 4'h0;
      end
   end

   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
      begin
         state_q <= ST_IDLE;
      end
      else if (bus_start)
      begin
         state_q <= ST_ADDR;
      end
      else if (bus_stop)
      begin
         state_q <= ST_IDLE;
      end
      else if (scl_fall)
      begin
         unique case (state_q)
            ST_IDLE: state_q <= ST_IDLE;
            ST_ADDR:
            begin
               if (byte_done)
               begin
                  state_q <= addr_hit ? ST_AACK : ST_WAIT;
               end
            end
            ST_AACK: state_q <= shift_q[0] ? ST_RDAT : ST_CMD;
            ST_CMD:
            begin
               if (byte_done)
               begin
                  state_q <= ST_CACK;
               end
            end
            ST_CACK: state_q <= ST_DATA;
            ST_DATA:
            begin
               if (byte_done)
               begin
                  state_q <= ST_DACK;
               end
            end
            ST_DACK: state_q <= ST_WAIT;
            ST_RDAT:
            begin
               if (byte_done)
               begin
                  state_q <= ST_RACK;
               end
            end
            ST_RACK: state_q <= ST_WAIT;
            ST_WAIT: state_q <= ST_WAIT;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Open-drain data: the enable pulls the line low, the output level stays zero.
   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
      begin
         SDA_OE <= 1'b0;
         SDA_OUT <= 1'b0;
         tx_q <= 8'h00;
      end
      else if (bus_start || bus_stop)
      begin
         SDA_OE <= 1'b0;
      end
      else if (scl_fall)
      begin
         unique case (state_q)
            ST_ADDR: SDA_OE <= byte_done && addr_hit;
            ST_CMD: SDA_OE <= byte_done;
            ST_DATA: SDA_OE <= byte_done;
            ST_AACK:
            begin
               SDA_OE <= shift_q[0] & ~rd_byte[7];
               tx_q <= {rd_byte[6:0], 1'b0};
            end
            ST_RDAT:
            begin
               SDA_OE <= ~byte_done & ~tx_q[7];
               tx_q <= {tx_q[6:0], 1'b0};
            end
            default: SDA_OE <= 1'b0;
         endcase
      end
   end

   // ******************************************************************
   // Command decode
   // ******************************************************************
   logic [2:0] cmd_q;
   logic [4:0] idx_q;
   logic apply_q;
   logic wr_pulse;
   logic single_wr;

   assign wr_pulse = (state_q == ST_DATA) && byte_done;
   assign single_wr = wr_pulse && ((cmd_q == CMD_STAGE) || (cmd_q == CMD_WR_APPLY));

   // The index survives a repeated start, so the read phase uses it.
   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
      begin
         cmd_q <= CMD_STAGE;
         idx_q <= 5'h00;
      end
      else if ((state_q == ST_CMD) && byte_done)
      begin
         cmd_q <= shift_q[CMD_MSB:CMD_LSB];
         idx_q <= shift_q[IDX_MSB:0];
      end
   end

   // Apply fires one cycle after the triggering byte so a 010 write is seen.
   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
      begin
         apply_q <= 1'b0;
      end
      else
      begin
         apply_q <= ((state_q == ST_CMD) && byte_done &&
                     (shift_q[CMD_MSB:CMD_LSB] == CMD_APPLY)) ||
                    (wr_pulse && (cmd_q == CMD_WR_APPLY));
      end
   end

   // ******************************************************************
   // Staged registers and active outputs
   // ******************************************************************
   logic [LEVEL_W-1:0] level_q [NCH];
   logic [DUTY_W-1:0] duty_q [NCH];
   logic [7:0] outctl_q;
   logic [1:0] status_code;

   for (genvar i = 0; i < NCH; i++) begin : g_chan
      always_ff @(posedge MCLK or posedge RST)
      begin
         if (RST)
         begin
            level_q[i] <= LEVEL_RST;
         end
         else if ((single_wr && (idx_q == IDX_LEVEL_BASE + 5'(i))) ||
                  (wr_pulse && (cmd_q == CMD_ALL_LEVEL)))
         begin
            level_q[i] <= shift_q[LEVEL_W-1:0];
         end
      end

      always_ff @(posedge MCLK or posedge RST)
      begin
         if (RST)
         begin
            duty_q[i] <= DUTY_RST;
         end
         else if ((single_wr && (idx_q == IDX_DUTY_BASE + 5'(i))) ||
                  (wr_pulse && (cmd_q == CMD_ALL_DUTY)))
         begin
            duty_q[i] <= shift_q[DUTY_W-1:0];
         end
      end

      // Only the switching commands move staged values to the outputs.
      always_ff @(posedge MCLK or posedge RST)
      begin
         if (RST)
         begin
            CH_SET[i] <= '{level: LEVEL_RST, duty: DUTY_RST};
            CH_ON[i] <= 1'b0;
         end
         else if (apply_q)
         begin
            CH_SET[i] <= '{level: level_q[i], duty: duty_q[i]};
            CH_ON[i] <= outctl_q[i];
         end
      end
   end

   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
      begin
         outctl_q <= OUTCTL_RST;
      end
      else if (single_wr && (idx_q == IDX_OUTCTL))
      begin
         outctl_q <= shift_q;
      end
   end

   assign status_code = pins_s.over_temp ? STAT_OVER_TEMP :
                        (LOW_POWER ? STAT_LOW_POWER : STAT_NORMAL);

   // Read-back of every register; unmapped indices read zero.
   always_comb
   begin
      rd_byte = 8'h00;
      if (idx_q < IDX_DUTY_BASE)
      begin
         rd_byte = {3'h0, level_q[idx_q[2:0]]};
      end
      else if (idx_q < IDX_OUTCTL)
      begin
         rd_byte = {2'h0, duty_q[idx_q[2:0]]};
      end
      else if (idx_q == IDX_OUTCTL)
      begin
         rd_byte = outctl_q;
      end
      else if (idx_q == IDX_STATUS)
      begin
         rd_byte = {6'h00, status_code};
      end
   end

   // ******************************************************************
   // Low power entry
   // ******************************************************************
   logic bus_idle;

   assign bus_idle = (state_q == ST_IDLE) && !bus_start && (CH_ON == '0);

   ledcp_idle #(
      .CYCLES(LP_CYCLES)
   ) u_idle (
      .clk(MCLK),
      .rst(RST),
      .idle(bus_idle),
      .low_power(LOW_POWER)
   );

   // ******************************************************************
   // Checks
   // ******************************************************************
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (RST);

   chk_foreign_addr: assert property ((state_q == ST_ADDR) && byte_done && !addr_hit
      |=> state_q == ST_WAIT && !SDA_OE)
      else $error("foreign address was not ignored");

   chk_read_branch: assert property ((state_q == ST_AACK) && scl_fall && !bus_start &&
      !bus_stop |=> state_q == (shift_q[0] ? ST_RDAT : ST_CMD))
      else $error("direction bit steered the wrong way");

   chk_ack_held: assert property ((state_q == ST_AACK || state_q == ST_CACK ||
      state_q == ST_DACK) && !$changed(state_q) |-> SDA_OE)
      else $error("acknowledge not driven");

   chk_read_release: assert property ((state_q == ST_RACK) |-> !SDA_OE)
      else $error("data line held after read byte");

   chk_stage_hold: assert property (wr_pulse && (cmd_q == CMD_STAGE) |=>
      $stable(CH_SET) && $stable(CH_ON) [*2])
      else $error("staged write reached the outputs");

   chk_apply_copy: assert property (apply_q |=> CH_ON == $past(outctl_q) &&
      CH_SET[0].level == $past(level_q[0]) && CH_SET[7].duty == $past(duty_q[7]))
      else $error("switching did not copy the staged set");

   chk_wr_apply: assert property (wr_pulse && (cmd_q == CMD_WR_APPLY) |=> apply_q
      ##1 CH_ON == $past(outctl_q))
      else $error("write-and-switch did not switch");

   chk_all_level: assert property (wr_pulse && (cmd_q == CMD_ALL_LEVEL) |=>
      level_q[0] == $past(shift_q[4:0]) && level_q[7] == $past(shift_q[4:0]))
      else $error("broadcast level not loaded");

   chk_all_duty: assert property (wr_pulse && (cmd_q == CMD_ALL_DUTY) |=>
      duty_q[0] == $past(shift_q[5:0]) && duty_q[7] == $past(shift_q[5:0]))
      else $error("broadcast duty not loaded");

   chk_reserved_noop: assert property (wr_pulse && (cmd_q > CMD_ALL_DUTY) |=>
      $stable(outctl_q) && $stable(level_q[3]) && $stable(duty_q[3]) && !apply_q)
      else $error("reserved command changed state");

endmodule : ledcp_top

// ===== ledcp_pkg.sv
// Shared constants, field positions and carrier types of the LED driver command port.
// Assumes a single 20 MHz system clock and open-drain bus pins resolved outside.
package ledcp_pkg;

   // ******************************************************************
   // Bus, command and register map
   // ******************************************************************
   localparam int NCH = 8;
   localparam logic [6:0] DEV_ADDR = 7'h1B;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam int CMD_MSB = 7;
   localparam int CMD_LSB = 5;
   localparam int IDX_MSB = 4;
   localparam logic [2:0] CMD_APPLY = 3'h0;
   localparam logic [2:0] CMD_STAGE = 3'h1;
   localparam logic [2:0] CMD_WR_APPLY = 3'h2;
   localparam logic [2:0] CMD_ALL_LEVEL = 3'h3;
   localparam logic [2:0] CMD_ALL_DUTY = 3'h4;
   localparam logic [4:0] IDX_LEVEL_BASE = 5'h00;
   localparam logic [4:0] IDX_DUTY_BASE = 5'h08;
   localparam logic [4:0] IDX_OUTCTL = 5'h10;
   localparam logic [4:0] IDX_STATUS = 5'h11;
   localparam int LEVEL_W = 5;
   localparam int DUTY_W = 6;

   // ******************************************************************
   // Reset values and status codes
   // ******************************************************************
   localparam logic [LEVEL_W-1:0] LEVEL_RST = 5'h00;
   localparam logic [DUTY_W-1:0] DUTY_RST = 6'h00;
   localparam logic [7:0] OUTCTL_RST = 8'h00;
   localparam logic [1:0] STAT_NORMAL = 2'h0;
   localparam logic [1:0] STAT_LOW_POWER = 2'h1;
   localparam logic [1:0] STAT_OVER_TEMP = 2'h2;

   // ******************************************************************
   // Timing
   // ******************************************************************
   localparam int MCLK_PERIOD_NS = 50;
   localparam int LP_DELAY_MS = 5;
   localparam int LP_CYCLES = (LP_DELAY_MS * 1000000) / MCLK_PERIOD_NS;

   // ******************************************************************
   // Types
   // ******************************************************************
   typedef struct packed {
      logic [LEVEL_W-1:0] level;
      logic [DUTY_W-1:0] duty;
   } ledcp_chan_t;

   typedef struct packed {
      logic scl;
      logic sda;
      logic over_temp;
   } ledcp_pins_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_ADDR = 4'h1,
      ST_AACK = 4'h3,
      ST_CMD = 4'h2,
      ST_CACK = 4'h6,
      ST_DATA = 4'h7,
      ST_DACK = 4'h5,
      ST_RDAT = 4'h4,
      ST_RACK = 4'hC,
      ST_WAIT = 4'hD
   } ledcp_state_t;

endpackage : ledcp_pkg

// ===== ledcp_sync.sv
// Two-stage synchroniser for asynchronous input levels.
// Assumes the inputs are levels that stay put long enough to be seen.
`timescale 1ns/1ps
module ledcp_sync #(
   parameter int W = 3,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input logic clk,
   input logic rst,
   input logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   if (W < 1) begin : g_bad_w
      $error("ledcp_sync: width must be at least one");
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         meta_q <= RST_VAL;
         q <= RST_VAL;
      end
      else
      begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule : ledcp_sync

// ===== ledcp_idle.sv
// Low power timer: raises its flag after a quiet interval with all outputs off.
// Assumes the idle input is a level on the same clock.
`timescale 1ns/1ps
module ledcp_idle #(
   parameter int CYCLES = 100000
) (
   input logic clk,
   input logic rst,
   input logic idle,
   output logic low_power
);
   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
   logic [CW-1:0] cnt_q;

   if (CYCLES < 1) begin : g_bad_cycles
      $error("ledcp_idle: interval must be at least one cycle");
   end

   // Any activity restarts the interval and wakes the device at once.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cnt_q <= '0;
         low_power <= 1'b0;
      end
      else if (!idle)
      begin
         cnt_q <= '0;
         low_power <= 1'b0;
      end
      else if (cnt_q == LAST)
      begin
         low_power <= 1'b1;
      end
      else
      begin
         cnt_q <= cnt_q + CW'(1);
      end
   end

   chk_lp_needs_wait: assert property (@(posedge clk) disable iff (rst)
      $rose(low_power) |-> $past(cnt_q) == LAST && $past(idle))
      else $error("low power entered before the quiet interval ended");
endmodule : ledcp_idle

// ===== ledcp_master.sv
// Bus controller model that drives the command port from outside.
// Assumes MCLK at 50 ns and a data wire resolved by the bench with a pull-up.
`timescale 1ns/1ps
module ledcp_master (
   input wire logic clk,
   input wire logic sda,
   output logic scl,
   output logic sda_drv
);
   import ledcp_pkg::*;

   // ******************************************************************
   // Bus cycles: one bit lasts 8 clocks, a 400 ns period
   // ******************************************************************
   initial
   begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end

   task automatic w(input int n);
      repeat (n) @(posedge clk);
   endtask : w

   // Only this model moves the clock and opens transfers; the bit period is a bench speed-up.
   task automatic cond(input logic a, input logic b);
      scl <= 1'b0;
      w(1);
      sda_drv <= a;
      w(4);
      scl <= 1'b1;
      w(4);
      sda_drv <= b;
      w(4);
   endtask : cond

   task automatic bit_io(input logic b, output logic r);
      scl <= 1'b0;
      w(1);
      sda_drv <= b;
      w(4);
      scl <= 1'b1;
      w(1);
      r = sda;
      w(2);
   endtask : bit_io

   // Bytes go out MSB first; the ninth clock carries the acknowledge.
   task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx,
         output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(tx[i], r);
         rx[i] = r;
      end
      bit_io(last, r);
      ack = ~r;
   endtask : xfer

   // Address with write bit, command byte, optional data byte, then stop.
   task automatic wr(input logic [2:0] code, input logic [4:0] idx, input logic [7:0] d,
         input logic send_data, output logic [2:0] acks);
      logic [7:0] rx;
      cond(1'b1, 1'b0);
      xfer({DEV_ADDR, 1'b0}, 1'b1, rx, acks[2]);
      xfer({code, idx}, 1'b1, rx, acks[1]);
      acks[0] = 1'b1;
      if (send_data)
         xfer(d, 1'b1, rx, acks[0]);
      cond(1'b0, 1'b1);
   endtask : wr

   // Select with code 001, repeated start, read one byte, no acknowledge, stop.
   task automatic rd(input logic [4:0] idx, output logic [7:0] d, output logic [2:0] acks);
      logic a;
      cond(1'b1, 1'b0);
      xfer({DEV_ADDR, 1'b0}, 1'b1, d, acks[2]);
      xfer({CMD_STAGE, idx}, 1'b1, d, acks[1]);
      cond(1'b1, 1'b0);
      xfer({DEV_ADDR, 1'b1}, 1'b1, d, acks[0]);
      xfer(8'hFF, 1'b1, d, a);
      cond(1'b0, 1'b1);
   endtask : rd

   task automatic raw(input logic [7:0] b, output logic ack);
      logic [7:0] rx;
      cond(1'b1, 1'b0);
      xfer(b, 1'b1, rx, ack);
      cond(1'b0, 1'b1);
   endtask : raw
endmodule : ledcp_master

// ===== ledcp_top_tb.sv
// Self-checking bench of the LED driver command port.
// Assumes the controller model of ledcp_master.sv and a 200-cycle low power delay.
`timescale 1ns/1ps
`define CHK(got, exp) \
   begin \
      tests_run++; \
      if ((got) !== (exp)) \
      begin \
         miscompares++; \
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp); \
      end \
   end

module ledcp_top_tb;
   import ledcp_pkg::*;

   // ******************************************************************
   // Clock, reset, wire and instances
   // ******************************************************************
   logic mclk;
   logic rst;
   logic over_temp;
   logic scl;
   logic sda_drv;
   logic sda_out;
   logic sda_oe;
   wire sda;
   logic [NCH-1:0] ch_on;
   ledcp_chan_t [NCH-1:0] ch_set;
   logic low_power;
   int miscompares;
   int tests_run;
   logic [2:0] acks;
   logic [7:0] rd_val;
   logic ack;

   assign sda = sda_drv & ~sda_oe;

   initial mclk = 1'b0;
   always #25 mclk = ~mclk;

   ledcp_top #(.LP_CYCLES(200)) u_dut (.MCLK(mclk), .RST(rst), .SCL(scl), .SDA_IN(sda),
      .SDA_OUT(sda_out), .SDA_OE(sda_oe), .OVER_TEMP(over_temp), .CH_ON(ch_on),
      .CH_SET(ch_set), .LOW_POWER(low_power));
   ledcp_master u_mst (.clk(mclk), .sda(sda), .scl(scl), .sda_drv(sda_drv));

   task automatic results();
      $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : results

   task automatic wr_ok(input logic [2:0] c, input logic [4:0] i, input logic [7:0] d);
      u_mst.wr(c, i, d, 1'b1, acks);
      `CHK(acks, 3'b111);
   endtask : wr_ok

   task automatic chk_rd(input logic [4:0] i, input logic [7:0] exp);
      u_mst.rd(i, rd_val, acks);
      `CHK(acks, 3'b111);
      `CHK(rd_val, exp);
   endtask : chk_rd

   // ******************************************************************
   // Scenarios
   // ******************************************************************
   task automatic t_reset();
      `CHK(ch_on, 8'h00);
      `CHK(ch_set, 88'h0);
      `CHK(sda_oe, 1'b0);
      `CHK(sda_out, 1'b0);
      `CHK(low_power, 1'b0);
      $display("test reset finished");
   endtask : t_reset

   task automatic t_addr();
      u_mst.raw(8'h38, ack);
      `CHK(ack, 1'b0);
      u_mst.raw(8'h36, ack);
      `CHK(ack, 1'b1);
      $display("test address finished");
   endtask : t_addr

   task automatic t_stage();
      wr_ok(CMD_STAGE, 5'h03, 8'hFF);
      wr_ok(CMD_STAGE, 5'h0A, 8'hFF);
      wr_ok(CMD_STAGE, 5'h10, 8'hA5);
      `CHK(ch_on, 8'h00);
      `CHK(ch_set, 88'h0);
      chk_rd(5'h03, 8'h1F);
      chk_rd(5'h0A, 8'h3F);
      chk_rd(5'h10, 8'hA5);
      $display("test stage finished");
   endtask : t_stage

   task automatic t_apply();
      u_mst.wr(CMD_APPLY, 5'h1F, 8'h00, 1'b0, acks);
      `CHK(acks[2:1], 2'b11);
      `CHK(ch_on, 8'hA5);
      `CHK(ch_set[3].level, 5'h1F);
      `CHK(ch_set[2].duty, 6'h3F);
      `CHK(ch_set[3].duty, 6'h00);
      $display("test apply finished");
   endtask : t_apply

   task automatic t_bcast();
      wr_ok(CMD_ALL_LEVEL, 5'h11, 8'h07);
      wr_ok(CMD_ALL_DUTY, 5'h10, 8'h21);
      `CHK(ch_set[3].level, 5'h1F);
      chk_rd(5'h05, 8'h07);
      chk_rd(5'h0F, 8'h21);
      chk_rd(5'h10, 8'hA5);
      wr_ok(CMD_WR_APPLY, 5'h10, 8'h0F);
      `CHK(ch_on, 8'h0F);
      for (int i = 0; i < NCH; i++)
         `CHK(ch_set[i], {5'h07, 6'h21});
      $display("test broadcast finished");
   endtask : t_bcast

   task automatic t_reserved();
      for (int c = 5; c < 8; c++)
      begin
         wr_ok(c[2:0], 5'h10, 8'h00);
         `CHK(ch_on, 8'h0F);
      end
      chk_rd(5'h10, 8'h0F);
      chk_rd(5'h00, 8'h07);
      $display("test reserved finished");
   endtask : t_reserved

   task automatic t_status();
      chk_rd(5'h11, 8'h00);
      over_temp <= 1'b1;
      chk_rd(5'h11, 8'h02);
      wr_ok(CMD_STAGE, 5'h11, 8'h01);
      chk_rd(5'h11, 8'h02);
      over_temp <= 1'b0;
      chk_rd(5'h15, 8'h00);
      $display("test status finished");
   endtask : t_status

   task automatic t_lowpower();
      int n;
      wr_ok(CMD_WR_APPLY, 5'h10, 8'h00);
      `CHK(ch_on, 8'h00);
      for (n = 0; n < 400 && low_power !== 1'b1; n++)
         @(posedge mclk);
      if (n == 400)
      begin
         miscompares++;
         results();
      end
      else
      begin
         `CHK(n > 150, 1'b1);
         u_mst.rd(5'h11, rd_val, acks);
         `CHK(acks, 3'b111);
         `CHK(rd_val, {6'h00, STAT_NORMAL});
         `CHK(low_power, 1'b0);
         $display("test low power finished");
      end
   endtask : t_lowpower

   initial
   begin
      rst = 1'b1;
      over_temp = 1'b0;
      miscompares = 0;
      tests_run = 0;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      repeat (4) @(posedge mclk);
      t_reset();
      t_addr();
      t_stage();
      t_apply();
      t_bcast();
      t_reserved();
      t_status();
      t_lowpower();
      results();
   end

   initial
   begin
      repeat (100000) @(posedge mclk);
      miscompares++;
      results();
   end
endmodule : ledcp_top_tb
